// ### common/dfpc_map.svh
// Offsets, field positions, reset values and step figures of the pull control bank
`ifndef DFPC_MAP_SVH
`define DFPC_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DFPC_ADDR_LOW 8'h00
`define DFPC_ADDR_HIGH 8'h01
`define DFPC_ADDR_RANGE 8'h02

// ----------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------
`define DFPC_WORD_W 26
`define DFPC_HIGH_W 10
`define DFPC_OE_BIT 10
`define DFPC_RANGE_W 4
`define DFPC_STEP_W 10

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define DFPC_LOW_RST 16'h0000
`define DFPC_HIGH_RST 10'h000
`define DFPC_WORD_RST 26'h0000000
`define DFPC_OE_RST 1'b0
`define DFPC_RANGE_FACTORY 4'h0
`define DFPC_WORD_NEG_EDGE 26'h2000000
`define DFPC_WORD_NEG_FULL 26'h2000001

// ----------------------------------------------------------------
// Step size per range code, in units of 1e-13
// ----------------------------------------------------------------
`define DFPC_CODE_400 4'hA
`define DFPC_CODE_600 4'hB
`define DFPC_CODE_800 4'hC
`define DFPC_CODE_1200 4'hD
`define DFPC_CODE_1600 4'hE
`define DFPC_CODE_3200 4'hF
`define DFPC_STEP_FINE 10'h032
`define DFPC_STEP_400 10'h064
`define DFPC_STEP_600 10'h08C
`define DFPC_STEP_800 10'h0D2
`define DFPC_STEP_1200 10'h140
`define DFPC_STEP_1600 10'h1D6
`define DFPC_STEP_3200 10'h3AC

`endif

// ### common/dfpc_pkg.sv
// Types and shared decode functions of the pull control bank
`include "dfpc_map.svh"
package dfpc_pkg;

  // Signed offset word, range code and step figure
  typedef logic [`DFPC_WORD_W-1:0] offset_word_t;
  typedef logic [`DFPC_RANGE_W-1:0] range_code_t;
  typedef logic [`DFPC_STEP_W-1:0] step_size_t;

  // Resolution of one word step for a range code
  function automatic step_size_t step_of(input range_code_t code);
    step_size_t s;
    s = `DFPC_STEP_FINE;
    unique case (code)
      `DFPC_CODE_400: s = `DFPC_STEP_400;
      `DFPC_CODE_600: s = `DFPC_STEP_600;
      `DFPC_CODE_800: s = `DFPC_STEP_800;
      `DFPC_CODE_1200: s = `DFPC_STEP_1200;
      `DFPC_CODE_1600: s = `DFPC_STEP_1600;
      `DFPC_CODE_3200: s = `DFPC_STEP_3200;
      default: s = `DFPC_STEP_FINE;
    endcase
    return s;
  endfunction

  // Keep the word inside the symmetric full scale
  function automatic offset_word_t clamp_word(input offset_word_t w);
    return (w == `DFPC_WORD_NEG_EDGE) ? `DFPC_WORD_NEG_FULL : w;
  endfunction

endpackage

// ### common/offset_commit_if.sv
// Commit path between the register bank and the offset applier
`timescale 1ns/1ps
interface offset_commit_if;
  logic commit;                       // One-cycle commit pulse
  dfpc_pkg::offset_word_t word;       // Word to apply
  dfpc_pkg::range_code_t range;       // Range to apply
  logic update;                       // One-cycle applied pulse
  dfpc_pkg::offset_word_t pull_word;  // Word in force
  dfpc_pkg::range_code_t pull_range;  // Range in force
  dfpc_pkg::step_size_t step;         // Step of range in force

  modport issuer (output commit, word, range, input update, pull_word, pull_range, step);
  modport applier (input commit, word, range, output update, pull_word, pull_range, step);
endinterface

// ### logic/offset_applier.sv
// Applies a committed offset word and range, the word clamped to the symmetric full scale
`timescale 1ns/1ps
`include "dfpc_map.svh"
module offset_applier #(
  parameter dfpc_pkg::range_code_t FACTORY_RANGE = `DFPC_RANGE_FACTORY
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  offset_commit_if.applier cmt
);

  // ----------------------------------------------------------------
  // State in force
  // ----------------------------------------------------------------
  dfpc_pkg::offset_word_t word_reg;   // Applied word
  dfpc_pkg::range_code_t range_reg;   // Applied range
  dfpc_pkg::step_size_t step_reg;     // Applied step
  logic update_reg;                   // Applied pulse

  // Clamped word and step of the incoming range
  wire dfpc_pkg::offset_word_t word_next = dfpc_pkg::clamp_word(cmt.word);
  wire dfpc_pkg::step_size_t step_next = dfpc_pkg::step_of(cmt.range);

  // Word, range and step load on commit only
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      word_reg <= `DFPC_WORD_RST;
      range_reg <= FACTORY_RANGE;
      step_reg <= dfpc_pkg::step_of(FACTORY_RANGE);
      update_reg <= 1'b0;
    end else begin
      update_reg <= cmt.commit;
      if (cmt.commit) begin
        word_reg <= word_next;
        range_reg <= cmt.range;
        step_reg <= step_next;
      end
    end
  end

  assign cmt.update = update_reg;
  assign cmt.pull_word = word_reg;
  assign cmt.pull_range = range_reg;
  assign cmt.step = step_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  sequence commit_seen;
    cmt.commit ##0 (cmt.word != `DFPC_WORD_NEG_EDGE);
  endsequence

  a_clamp_bound: assert property (word_reg != `DFPC_WORD_NEG_EDGE)
    else $error("applied word outside range");
  a_update_follows: assert property (commit_seen |=> update_reg && word_reg == $past(cmt.word))
    else $error("commit not applied next cycle");
  a_step_matches: assert property (step_reg == dfpc_pkg::step_of(range_reg))
    else $error("step does not match range");
  a_sign_kept: assert property (cmt.commit |=> word_reg[25] == $past(cmt.word[25]))
    else $error("offset sign lost");

endmodule // offset_applier

// ### logic/digital_frequency_pull_control.sv
// Register bank of the digitally trimmed oscillator pull control
`timescale 1ns/1ps
`include "dfpc_map.svh"
module digital_frequency_pull_control #(
  parameter dfpc_pkg::range_code_t FACTORY_RANGE = `DFPC_RANGE_FACTORY
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic oe_sw_ctrl_i,
  input wire logic oe_pin_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic output_enable_o,
  output logic [25:0] pull_word_o,
  output logic [3:0] pull_range_o,
  output logic [9:0] step_size_o,
  output logic freq_update_o
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Register selects, shared by writes and reads
  wire logic sel_low = (reg_addr_i == `DFPC_ADDR_LOW);
  wire logic sel_high = (reg_addr_i == `DFPC_ADDR_HIGH);
  wire logic sel_range = (reg_addr_i == `DFPC_ADDR_RANGE);

  // Write strobes per register
  wire logic wr_low = reg_wr_i && sel_low;
  wire logic wr_high = reg_wr_i && sel_high;
  wire logic wr_range = reg_wr_i && sel_range;

  // Enable bit is writable only under software control
  wire logic wr_oe = wr_high && oe_sw_ctrl_i;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [15:0] stage_low_reg;        // Written low half, not yet applied
  logic [15:0] active_low_reg;       // Low half of the committed word
  logic [9:0] high_reg;              // High half of the committed word
  logic oe_reg;                      // Software output enable bit
  dfpc_pkg::range_code_t range_reg;  // Selected pull range
  logic commit_reg;                  // One-cycle commit toward the applier
  logic [15:0] rdata_reg;            // Read data held for the host
  logic rvalid_reg;                  // Read answer strobe
  logic oe_out_reg;                  // Output driver enable

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  // Low half only lands in staging; frequency unchanged
  wire logic [15:0] stage_low_next = wr_low ? reg_wdata_i : stage_low_reg;

  // High half write moves staging into the active word
  wire logic [15:0] active_low_next = wr_high ? stage_low_reg : active_low_reg;
  wire logic [9:0] high_next = wr_high ? reg_wdata_i[9:0] : high_reg;

  // Enable bit follows writes only when allowed
  wire logic oe_next = wr_oe ? reg_wdata_i[`DFPC_OE_BIT] : oe_reg;

  // Range field, upper bits dropped
  wire dfpc_pkg::range_code_t range_next = wr_range ? reg_wdata_i[3:0] : range_reg;

  // A new word or a new range both reach the applier
  wire logic commit_next = wr_high || wr_range;

  // Driver enable from the bit or from the pin
  wire logic oe_out_next = oe_sw_ctrl_i ? oe_next : oe_pin_i;

  // Read views, unused bits tied to zero
  wire logic [15:0] view_low = stage_low_reg;
  wire logic [15:0] view_high = {5'h00, oe_reg, high_reg};
  wire logic [15:0] view_range = {12'h000, range_reg};

  // Read multiplexer, unmapped offsets return zero
  wire logic [15:0] rdata_next = sel_low ? view_low :
                                 sel_high ? view_high :
                                 sel_range ? view_range : 16'h0000;

  // ----------------------------------------------------------------
  // Offset word registers
  // ----------------------------------------------------------------
  // Both halves reset to the nominal-frequency word
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      stage_low_reg <= `DFPC_LOW_RST;
      active_low_reg <= `DFPC_LOW_RST;
      high_reg <= `DFPC_HIGH_RST;
    end else begin
      stage_low_reg <= stage_low_next;
      active_low_reg <= active_low_next;
      high_reg <= high_next;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Enable bit disabled and range at factory value after reset
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      oe_reg <= `DFPC_OE_RST;
      range_reg <= FACTORY_RANGE;
      oe_out_reg <= 1'b0;
    end else begin
      oe_reg <= oe_next;
      range_reg <= range_next;
      oe_out_reg <= oe_out_next;
    end
  end

  // ----------------------------------------------------------------
  // Commit and read answer
  // ----------------------------------------------------------------
  // Commit pulses one cycle after the write is taken
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      commit_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      commit_reg <= commit_next;
      rvalid_reg <= reg_rd_i;
      if (reg_rd_i) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // Offset applier
  // ----------------------------------------------------------------
  // Carries the committed word and range, returns what is in force
  offset_commit_if cmt ();

  assign cmt.commit = commit_reg;
  assign cmt.word = {high_reg, active_low_reg};
  assign cmt.range = range_reg;

  // Clamps and holds the applied setting
  offset_applier #(
    .FACTORY_RANGE(FACTORY_RANGE)
  ) u_applier (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .cmt(cmt)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // All straight from flip-flops here or in the applier
  assign reg_rdata_o = rdata_reg;
  assign reg_rvalid_o = rvalid_reg;
  assign output_enable_o = oe_out_reg;
  assign pull_word_o = cmt.pull_word;
  assign pull_range_o = cmt.pull_range;
  assign step_size_o = cmt.step;
  assign freq_update_o = cmt.update;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  // Low write followed by high write
  sequence low_then_high;
    wr_low ##1 wr_high;
  endsequence

  // Low write alone starts nothing
  a_low_no_commit: assert property (wr_low && !wr_range |=> !commit_reg ##1 $stable(pull_word_o))
    else $error("low half write changed frequency");

  // High write commits staged low and written high together
  a_high_commits: assert property (
    wr_high |=> commit_reg && cmt.word == {$past(reg_wdata_i[9:0]), $past(stage_low_reg)})
    else $error("high half write did not commit word");

  // Ordered update reaches the output two cycles after the high write
  a_ordered_update: assert property (
    low_then_high |-> ##2 freq_update_o
      && pull_word_o == dfpc_pkg::clamp_word({$past(reg_wdata_i[9:0], 2),
                                              $past(reg_wdata_i, 3)}))
    else $error("ordered update not applied");

  // Enable bit frozen under pin control
  a_oe_ignored: assert property (wr_high && !oe_sw_ctrl_i |=> $stable(oe_reg))
    else $error("enable bit written under pin control");

  // Unused bits read zero
  a_reserved_zero: assert property (
    reg_rd_i && sel_high |=> reg_rvalid_o && reg_rdata_o[15:11] == 5'h00)
    else $error("unused bits of high register not zero");
  a_range_reserved: assert property (
    reg_rd_i && sel_range |=> reg_rdata_o[15:4] == 12'h000)
    else $error("unused bits of range register not zero");

  // Range write lands and is applied two cycles later
  a_range_write: assert property (
    wr_range |=> range_reg == $past(reg_wdata_i[3:0])
      ##1 pull_range_o == $past(reg_wdata_i[3:0], 2))
    else $error("range write not applied");

  // Values right after reset release
  a_reset_state: assert property (
    $rose(rst_n_i) |-> pull_word_o == `DFPC_WORD_RST && !oe_reg && range_reg == FACTORY_RANGE
      && pull_range_o == FACTORY_RANGE)
    else $error("power-up state wrong");

  // ----------------------------------------------------------------
  // Enable, staging, read-answer and range checks
  // ----------------------------------------------------------------
  // Any of the three mapped offsets
  wire logic sel_any = sel_low || sel_high || sel_range;

  // Under software control the driver follows the enable bit
  a_oe_software: assert property (oe_sw_ctrl_i |=> output_enable_o == oe_reg)
    else $error("driver enable differs from software bit");

  // Under pin control the driver follows the pin one cycle late
  a_oe_pin: assert property (!oe_sw_ctrl_i |=> output_enable_o == $past(oe_pin_i))
    else $error("driver enable differs from pin");

  // Enable bit lands from its field of a high write
  a_oe_write: assert property (
    wr_high && oe_sw_ctrl_i |=> oe_reg == $past(reg_wdata_i[`DFPC_OE_BIT]))
    else $error("enable bit write lost");

  // Unmapped offsets answer zero
  a_unmapped_zero: assert property (
    reg_rd_i && !sel_any |=> reg_rvalid_o && reg_rdata_o == 16'h0000)
    else $error("unmapped read not zero");

  // No read answer without a read request
  a_no_stray_answer: assert property (!reg_rd_i |=> !reg_rvalid_o)
    else $error("read answer without request");

  // Low write only fills staging, the committed half stays put
  a_low_staged: assert property (
    wr_low |=> stage_low_reg == $past(reg_wdata_i) && $stable(active_low_reg))
    else $error("low half write not staged");

  // Offset writes leave the selected range alone
  a_range_held: assert property (wr_low || wr_high |=> $stable(range_reg))
    else $error("offset write changed range");

  // Range write reapplies the committed word, clamped, two cycles later
  a_range_update: assert property (
    wr_range |-> ##2 freq_update_o && pull_word_o == dfpc_pkg::clamp_word($past(cmt.word)))
    else $error("range write did not reapply word");

endmodule // digital_frequency_pull_control

// ### bench/dfpc_host_model.sv
// Host-side model that issues register writes and reads to the pull control bank
`timescale 1ns/1ps
module dfpc_host_model (
  input wire logic clock_i,
  input wire logic [15:0] rdata_i,
  input wire logic rvalid_i,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] addr_o,
  output logic [15:0] wdata_o
);
  // Bus idle from time zero
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 16'h0000;
  end

  // Spacing before an offset update keeps the update rate under 38 kHz
  task automatic pace_update();
    repeat (2700) @(posedge clock_i);
  endtask

  // One write; the bank takes it at the second edge, then the lines are scrambled
  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    if (a == 8'h01) begin
      pace_update();
    end
    @(posedge clock_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clock_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask

  // One read; the answer is sampled one cycle after the taking edge
  task automatic read_reg(input logic [7:0] a, output logic [15:0] d, output logic v);
    @(posedge clock_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge clock_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(posedge clock_i);
    v = rvalid_i;
    d = rdata_i;
  endtask

  // Whole word update, low half first, enable bit kept with the high half
  // Both halves go out back to back, strobe held high between them
  task automatic set_offset(input logic [25:0] w, input logic oe);
    pace_update();
    @(posedge clock_i);
    wr_o <= 1'b1;
    addr_o <= 8'h00;
    wdata_o <= w[15:0];
    @(posedge clock_i);
    addr_o <= 8'h01;
    wdata_o <= {5'h00, oe, w[25:16]};
    @(posedge clock_i);
    wr_o <= 1'b0;
    addr_o <= 8'hFE;
    wdata_o <= 16'h0000;
  endtask
endmodule // dfpc_host_model

// ### bench/tb_digital_frequency_pull_control.sv
// Self-checking testbench of the pull control register bank
`timescale 1ns/1ps
module tb_digital_frequency_pull_control;
  logic clock_i, rst_n_i, oe_sw_ctrl_i, oe_pin_i;
  logic reg_wr_i, reg_rd_i, reg_rvalid_o, output_enable_o, freq_update_o;
  logic [7:0] reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, rd_val;
  logic [25:0] pull_word_o;
  logic [3:0] pull_range_o;
  logic [9:0] step_size_o;
  logic rd_ok, upd_seen;
  int err_total, num_checks, cycles;
  // Expected step per range code, units of 1e-13
  logic [9:0] step_tab [16] = '{10'h032, 10'h032, 10'h032, 10'h032, 10'h032, 10'h032,
    10'h032, 10'h032, 10'h032, 10'h032, 10'h064, 10'h08C, 10'h0D2, 10'h140, 10'h1D6, 10'h3AC};

  digital_frequency_pull_control i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .oe_sw_ctrl_i(oe_sw_ctrl_i), .oe_pin_i(oe_pin_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .output_enable_o(output_enable_o), .pull_word_o(pull_word_o),
    .pull_range_o(pull_range_o), .step_size_o(step_size_o), .freq_update_o(freq_update_o));

  dfpc_host_model i_host (.clock_i(clock_i), .rdata_i(reg_rdata_o), .rvalid_i(reg_rvalid_o),
    .wr_o(reg_wr_i), .rd_o(reg_rd_i), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));

  // 100 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  // Counts and reports one comparison
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Read a register and compare its answer
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    i_host.read_reg(a, rd_val, rd_ok);
    chk("rvalid", {31'd0, rd_ok}, 32'd1);
    chk("rdata", {16'd0, rd_val}, {16'd0, exp});
  endtask

  // Bounded wait for the applied pulse
  task automatic wait_upd();
    upd_seen = 1'b0;
    repeat (8) begin
      @(posedge clock_i);
      #1;
      if (freq_update_o === 1'b1) begin
        upd_seen = 1'b1;
        break;
      end
    end
  endtask

  // Prints counts and the verdict, then stops
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Hang guard, five paced offset updates of 2700 cycles plus the rest
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    err_total = 0;
    num_checks = 0;
    cycles = 0;
    rst_n_i = 1'b0;
    oe_sw_ctrl_i = 1'b1;
    oe_pin_i = 1'b0;
    repeat (16) @(posedge clock_i);
    #1;
    // Power-up state: nominal, factory range, output off
    chk("word", pull_word_o, 0);
    chk("range", pull_range_o, 0);
    chk("step", step_size_o, 10'h032);
    chk("oe", output_enable_o, 0);
    @(posedge clock_i);
    rst_n_i <= 1'b1;
    rd_chk(8'h00, 16'h0000);
    rd_chk(8'h01, 16'h0000);
    rd_chk(8'h02, 16'h0000);
    $display("test reset done");
    // Low half alone only stages
    i_host.write_reg(8'h00, 16'h1234);
    wait_upd();
    chk("no update", upd_seen, 0);
    chk("word held", pull_word_o, 0);
    rd_chk(8'h00, 16'h1234);
    $display("test staging done");
    // Word for +90 ppm in 200 ppm range, junk in unused high bits
    i_host.write_reg(8'h00, 16'h6666);
    i_host.write_reg(8'h01, 16'hFCE6);
    wait_upd();
    chk("update", upd_seen, 1);
    chk("word", pull_word_o, 26'h0E66666);
    chk("oe on", output_enable_o, 1);
    rd_chk(8'h01, 16'h04E6);
    // High half alone reuses the staged low half
    i_host.write_reg(8'h01, 16'h0001);
    wait_upd();
    chk("word", pull_word_o, 26'h0016666);
    chk("oe off", output_enable_o, 0);
    // Most negative word kept inside the symmetric full scale
    i_host.set_offset(26'h2000000, 1'b1);
    wait_upd();
    chk("clamp", pull_word_o, 26'h2000001);
    // -50 ppm example, negative two's complement
    i_host.set_offset(26'h3800000, 1'b1);
    wait_upd();
    chk("negative", pull_word_o, 26'h3800000);
    $display("test offset done");
    // Every range code, unused bits set
    for (int i = 0; i < 16; i++) begin
      i_host.write_reg(8'h02, 16'hFFF0 | 16'(i));
      wait_upd();
      chk("range upd", upd_seen, 1);
      chk("range", pull_range_o, i);
      chk("step", step_size_o, step_tab[i]);
      chk("word kept", pull_word_o, 26'h3800000);
      rd_chk(8'h02, 16'(i));
    end
    $display("test range done");
    // Pin control: enable bit writes ignored
    @(posedge clock_i);
    oe_sw_ctrl_i <= 1'b0;
    oe_pin_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    #1;
    chk("oe pin", output_enable_o, 1);
    i_host.write_reg(8'h01, 16'h0000);
    wait_upd();
    chk("oe pin", output_enable_o, 1);
    rd_chk(8'h01, 16'h0400);
    @(posedge clock_i);
    oe_pin_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    #1;
    chk("oe pin off", output_enable_o, 0);
    $display("test enable done");
    // Unmapped place reads zero and ignores writes
    i_host.write_reg(8'h05, 16'hFFFF);
    rd_chk(8'h05, 16'h0000);
    rd_chk(8'h02, 16'h000F);
    // Second reset in mid-run
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rd_chk(8'h02, 16'h0000);
    rd_chk(8'h00, 16'h0000);
    chk("word", pull_word_o, 0);
    $display("test misc done");
    give_verdict();
  end
endmodule // tb_digital_frequency_pull_control
